// ### bsl_regs.vh
// Register map, field codes and timing constants of the serial link supervisor.
// Assumes a 10 MHz clock and Avalon-MM word addressing by byte address.
`ifndef BSL_REGS_VH
`define BSL_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define BSL_OFS_FRAME_FMT    6'h00
`define BSL_OFS_TURNAROUND   6'h04
`define BSL_OFS_LINK_OK      6'h08
`define BSL_OFS_ERR_CODE     6'h0c
`define BSL_OFS_LOSS_TIMEOUT 6'h10
`define BSL_OFS_LOSS_ACTION  6'h14
`define BSL_OFS_CRC_COUNT    6'h18
`define BSL_OFS_CONTROL      6'h1c
`define BSL_OFS_IRQ_STATUS   6'h20
`define BSL_OFS_IRQ_MASK     6'h24
`define BSL_OFS_LINK_STATUS  6'h28

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BSL_RST_FRAME_FMT    8'h00
`define BSL_RST_TURNAROUND   8'h05
`define BSL_RST_LOSS_TIMEOUT 16'h003c
`define BSL_RST_LOSS_ACTION  8'h00

// ----------------------------------------------------------------------------
// Protocol, format, action and error codes
// ----------------------------------------------------------------------------
`define BSL_PROTO_MODBUS     2'h0
`define BSL_PROTO_BACNET     2'h1
`define BSL_PROTO_TRAFFIC    2'h2
`define BSL_FMT_N1           8'h01
`define BSL_FMT_N2           8'h02
`define BSL_FMT_E1           8'h03
`define BSL_FMT_O1           8'h04
`define BSL_PAR_NONE         2'h0
`define BSL_PAR_EVEN         2'h1
`define BSL_PAR_ODD          2'h2
`define BSL_ACT_NONE         8'h00
`define BSL_ACT_TRIP         8'h01
`define BSL_ACT_PRESET       8'h02
`define BSL_ERR_NONE         8'h00
`define BSL_ERR_OS           8'h0a
`define BSL_ERR_RTC          8'h14
`define BSL_ERR_FAN          8'h1e
`define BSL_ERR_DRIVE_IF     8'h28
`define BSL_ERR_NETWORK      8'h32
`define BSL_ERR_OVERTEMP     8'h4a
`define BSL_CRC_MAX          15'h7fff
`define BSL_LOSS_MIN_S       16'h0005

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BSL_CLK_HZ           10000000
`define BSL_MS_NS            1000000
`define BSL_CLK_NS           100
`define BSL_MS_CYCLES        (`BSL_MS_NS / `BSL_CLK_NS)
`define BSL_MS_PER_S         1000

`endif

// ### bsl_link_supervisor.v
// Serial building-automation link supervisor: framing selection, response
// timing, end-of-message detection, CRC error count, link-loss watch, faults.
// Assumes a UART core outside that reports character and message events as
// same-clock pulses and obeys the tx enable and go strobes issued here.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "bsl_regs.vh"

module bsl_link_supervisor #(
  parameter MS_CYCLES = `BSL_MS_CYCLES,
  parameter MS_PER_S  = `BSL_MS_PER_S
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [1:0]  protocol_sel,
  input  wire [15:0] char_time_cycles,
  input  wire        rx_char_pulse,
  input  wire        rx_msg_done,
  input  wire        rx_msg_crc_err,
  input  wire        token_seen,
  input  wire        response_ready,
  input  wire [5:0]  fault_in,
  output reg         msg_end_pulse,
  output reg         msg_accept,
  output reg         tx_enable,
  output reg         tx_go,
  output reg         stop_bits_two,
  output reg  [1:0]  parity_mode,
  output reg         option_slot_fault_trip,
  output reg         preset_speed_load,
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Reset synchroniser and registers
  // --------------------------------------------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_ENAB = 4'b0100;
  localparam S_SEND = 4'b1000;

  reg        rst_meta_reg;
  reg        rst_sync_reg;
  reg [7:0]  frame_format_select_reg;
  reg [7:0]  response_turnaround_ms_reg;
  reg [15:0] link_loss_timeout_reg;
  reg [7:0]  link_loss_action_reg;
  reg [14:0] crc_error_counter_reg;
  reg [7:0]  module_error_code_reg;
  reg        link_ok_flag_reg;
  reg [3:0]  irq_status_reg;
  reg [3:0]  irq_mask_reg;
  reg [3:0]  state_reg;
  reg [23:0] quiet_reg;
  reg [23:0] resp_reg;
  reg [15:0] ms_div_reg;
  reg [9:0]  ms_in_s_reg;
  reg [15:0] loss_s_reg;
  reg        rd_pending_reg;

  wire       ms_tick  = (ms_div_reg == MS_CYCLES - 1);
  wire       s_tick   = ms_tick && (ms_in_s_reg == MS_PER_S - 1);
  wire       is_modbus = (protocol_sel == `BSL_PROTO_MODBUS);

  // Converts a count of milliseconds to clock cycles.
  // The product is cut to 24 bits on purpose; 255 ms fits well inside that range.
  function [23:0] ms_to_cycles;
    input [7:0]  ms;
    reg   [31:0] prod;
    begin
      prod         = ms * MS_CYCLES;
      ms_to_cycles = prod[23:0];
    end
  endfunction

  // Two-stage release keeps the reset edge clear of the clock, so every register
  // leaves reset on the same edge.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Character framing
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      stop_bits_two <= 1'b1;
      parity_mode   <= `BSL_PAR_NONE;
    end else begin
      case (frame_format_select_reg)
        `BSL_FMT_N1: begin
          stop_bits_two <= 1'b0;
          parity_mode   <= `BSL_PAR_NONE;
        end
        `BSL_FMT_N2: begin
          stop_bits_two <= 1'b1;
          parity_mode   <= `BSL_PAR_NONE;
        end
        `BSL_FMT_E1: begin
          stop_bits_two <= 1'b0;
          parity_mode   <= `BSL_PAR_EVEN;
        end
        `BSL_FMT_O1: begin
          stop_bits_two <= 1'b0;
          parity_mode   <= `BSL_PAR_ODD;
        end
        // Any other selector value falls back to the protocol's own framing.
        default: begin
          stop_bits_two <= is_modbus;
          parity_mode   <= `BSL_PAR_NONE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // End-of-message silence and response timing
  // --------------------------------------------------------------------------
  wire [23:0] char_35 = {7'h00, char_time_cycles, 1'b0}
                        + {8'h00, char_time_cycles}
                        + {9'h000, char_time_cycles[15:1]};
  wire [23:0] ta_cyc  = ms_to_cycles(response_turnaround_ms_reg);
  wire [23:0] silence = (char_35 > ta_cyc) ? char_35 : ta_cyc;
  wire [23:0] one_ms  = ms_to_cycles(8'h01);
  wire [23:0] en_wait = (response_turnaround_ms_reg > 8'h01) ? ta_cyc : one_ms;

  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      quiet_reg     <= 24'h000000;
      msg_end_pulse <= 1'b0;
    end else begin
      msg_end_pulse <= 1'b0;
      if (rx_char_pulse) begin
        quiet_reg <= 24'h000001;
      end else if (quiet_reg != 24'h000000) begin
        if (is_modbus && quiet_reg >= silence) begin
          msg_end_pulse <= 1'b1;
          quiet_reg     <= 24'h000000;
        end else begin
          quiet_reg <= quiet_reg + 24'h000001;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg  <= S_IDLE;
      resp_reg   <= 24'h000000;
      tx_enable  <= 1'b0;
      tx_go      <= 1'b0;
      msg_accept <= 1'b0;
    end else begin
      tx_go      <= 1'b0;
      msg_accept <= rx_msg_done && !rx_msg_crc_err;
      case (state_reg)
        S_IDLE: begin
          tx_enable <= 1'b0;
          if (is_modbus && rx_msg_done && !rx_msg_crc_err) begin
            state_reg <= S_WAIT;
            resp_reg  <= 24'h000001;
          end
        end
        // The response is held back until the UART has data queued; the wait count
        // keeps running, so a late response gets tx_enable at once and tx_go one ms later unless the turnaround is 0.
        S_WAIT: begin
          resp_reg <= resp_reg + 24'h000001;
          if (resp_reg >= en_wait && response_ready) begin
            tx_enable <= 1'b1;
            resp_reg  <= 24'h000001;
            if (response_turnaround_ms_reg == 8'h00) begin
              tx_go     <= 1'b1;
              state_reg <= S_SEND;
            end else begin
              state_reg <= S_ENAB;
            end
          end
        end
        S_ENAB: begin
          resp_reg <= resp_reg + 24'h000001;
          if (resp_reg >= one_ms) begin
            tx_go     <= 1'b1;
            state_reg <= S_SEND;
          end
        end
        // A new character means the host is talking again, so the line is released.
        S_SEND: begin
          if (rx_char_pulse || !response_ready) begin
            tx_enable <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Link loss watch
  // --------------------------------------------------------------------------
  wire [15:0] loss_limit = (link_loss_timeout_reg[15] ||
                            link_loss_timeout_reg <= `BSL_LOSS_MIN_S)
                           ? `BSL_LOSS_MIN_S : link_loss_timeout_reg;
  wire        healthy = (protocol_sel == `BSL_PROTO_BACNET) ? token_seen
                        : (rx_msg_done && !rx_msg_crc_err);
  // Loss is judged on whole-second ticks only, so it is declared between one
  // second short of the timeout and the timeout itself.
  wire        loss_now = link_ok_flag_reg && !healthy && s_tick &&
                         (loss_s_reg + 16'h0001 >= loss_limit);
  wire        crc_evt  = rx_msg_done && rx_msg_crc_err;
  wire        fault_evt = (fault_in != 6'h00) && (module_error_code_reg == `BSL_ERR_NONE);

  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ms_div_reg        <= 16'h0000;
      ms_in_s_reg       <= 10'h000;
      loss_s_reg        <= 16'h0000;
      link_ok_flag_reg  <= 1'b1;
      preset_speed_load <= 1'b0;
    end else begin
      ms_div_reg        <= ms_tick ? 16'h0000 : ms_div_reg + 16'h0001;
      if (ms_tick)
        ms_in_s_reg <= (ms_in_s_reg == MS_PER_S - 1) ? 10'h000 : ms_in_s_reg + 10'h001;
      preset_speed_load <= 1'b0;
      if (is_modbus || healthy) begin
        loss_s_reg       <= 16'h0000;
        link_ok_flag_reg <= 1'b1;
      end else if (loss_now) begin
        link_ok_flag_reg  <= 1'b0;
        preset_speed_load <= (link_loss_action_reg == `BSL_ACT_PRESET);
      end else if (s_tick && link_ok_flag_reg) begin
        loss_s_reg <= loss_s_reg + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // CRC count, faults and interrupts
  // --------------------------------------------------------------------------
  reg [7:0] fault_code;
  always @* begin
    fault_code = `BSL_ERR_NONE;
    if (fault_in[5])      fault_code = `BSL_ERR_OVERTEMP;
    else if (fault_in[4]) fault_code = `BSL_ERR_NETWORK;
    else if (fault_in[3]) fault_code = `BSL_ERR_DRIVE_IF;
    else if (fault_in[2]) fault_code = `BSL_ERR_FAN;
    else if (fault_in[1]) fault_code = `BSL_ERR_RTC;
    else if (fault_in[0]) fault_code = `BSL_ERR_OS;
  end

  // A write lands on the edge where the master sees waitrequest low, never on the
  // edge that takes the request, so each register changes exactly once.
  wire       wr_hit = avs_write && !avs_waitrequest;
  wire [3:0] irq_evt = {fault_evt, loss_now, link_ok_flag_reg == 1'b0 && healthy, crc_evt};

  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      crc_error_counter_reg  <= 15'h0000;
      module_error_code_reg  <= `BSL_ERR_NONE;
      option_slot_fault_trip <= 1'b0;
      irq_status_reg         <= 4'h0;
      irq                    <= 1'b0;
    end else begin
      if (crc_evt)
        crc_error_counter_reg <= (crc_error_counter_reg == `BSL_CRC_MAX) ? 15'h0000
                                 : crc_error_counter_reg + 15'h0001;
      // A module fault outranks a link-loss trip in the same cycle, but a later trip overwrites its code;
      // the trip flag holds until software writes the clear bit.
      if (fault_evt) begin
        module_error_code_reg  <= fault_code;
        option_slot_fault_trip <= 1'b1;
      end else if (loss_now && link_loss_action_reg == `BSL_ACT_TRIP) begin
        module_error_code_reg  <= `BSL_ERR_NETWORK;
        option_slot_fault_trip <= 1'b1;
      end else if (wr_hit && avs_address == `BSL_OFS_CONTROL && avs_writedata[0]) begin
        module_error_code_reg  <= `BSL_ERR_NONE;
        option_slot_fault_trip <= 1'b0;
      end
      // An event in the same cycle as its clear wins, so no event is lost.
      if (wr_hit && avs_address == `BSL_OFS_IRQ_STATUS)
        irq_status_reg <= (irq_status_reg & ~avs_writedata[3:0]) | irq_evt;
      else
        irq_status_reg <= irq_status_reg | irq_evt;
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the second edge
  // --------------------------------------------------------------------------
  // Every request gets exactly one wait cycle; read data are captured on the
  // taking edge and stand until the next read.
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      frame_format_select_reg    <= `BSL_RST_FRAME_FMT;
      response_turnaround_ms_reg <= `BSL_RST_TURNAROUND;
      link_loss_timeout_reg      <= `BSL_RST_LOSS_TIMEOUT;
      link_loss_action_reg       <= `BSL_RST_LOSS_ACTION;
      irq_mask_reg               <= 4'h0;
      avs_waitrequest            <= 1'b1;
      avs_readdata               <= 32'h00000000;
      rd_pending_reg             <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest && !rd_pending_reg) begin
        avs_waitrequest <= 1'b0;
        rd_pending_reg  <= 1'b1;
      end else begin
        rd_pending_reg <= 1'b0;
      end
      if (wr_hit) begin
        case (avs_address)
          `BSL_OFS_FRAME_FMT:    frame_format_select_reg    <= avs_writedata[7:0];
          `BSL_OFS_TURNAROUND:   response_turnaround_ms_reg <= avs_writedata[7:0];
          `BSL_OFS_LOSS_TIMEOUT: link_loss_timeout_reg      <= avs_writedata[15:0];
          `BSL_OFS_LOSS_ACTION:  link_loss_action_reg       <= avs_writedata[7:0];
          `BSL_OFS_IRQ_MASK:     irq_mask_reg               <= avs_writedata[3:0];
          default: ;
        endcase
      end
      if (avs_read && avs_waitrequest && !rd_pending_reg) begin
        case (avs_address)
          `BSL_OFS_FRAME_FMT:    avs_readdata <= {24'h000000, frame_format_select_reg};
          `BSL_OFS_TURNAROUND:   avs_readdata <= {24'h000000, response_turnaround_ms_reg};
          `BSL_OFS_LINK_OK:      avs_readdata <= {31'h00000000, link_ok_flag_reg};
          `BSL_OFS_ERR_CODE:     avs_readdata <= {24'h000000, module_error_code_reg};
          `BSL_OFS_LOSS_TIMEOUT: avs_readdata <= {16'h0000, link_loss_timeout_reg};
          `BSL_OFS_LOSS_ACTION:  avs_readdata <= {24'h000000, link_loss_action_reg};
          `BSL_OFS_CRC_COUNT:    avs_readdata <= {17'h00000, crc_error_counter_reg};
          `BSL_OFS_CONTROL:      avs_readdata <= {31'h00000000, option_slot_fault_trip};
          `BSL_OFS_IRQ_STATUS:   avs_readdata <= {28'h0000000, irq_status_reg};
          `BSL_OFS_IRQ_MASK:     avs_readdata <= {28'h0000000, irq_mask_reg};
          `BSL_OFS_LINK_STATUS:  avs_readdata <= {28'h0000000, state_reg};
          default:               avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // bsl_link_supervisor

// ### bsl_asserts.sv
// Concurrent checks on the link supervisor's ports: bus answer, response timing, framing.
// Assumes a bind to bsl_link_supervisor and one clock domain.
`timescale 1ns/10ps
module bsl_chk #(
  parameter MS_CYCLES = 10
) (
  input wire        clk,
  input wire        reset_n,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire [15:0] char_time_cycles,
  input wire        rx_char_pulse,
  input wire        rx_msg_done,
  input wire [5:0]  fault_in,
  input wire        msg_end_pulse,
  input wire        tx_enable,
  input wire        tx_go,
  input wire        stop_bits_two,
  input wire [1:0]  parity_mode,
  input wire        option_slot_fault_trip,
  input wire        preset_speed_load
);
  // --------------------------------------------------------------------------
  // Cycle counters since the last character, message end and transmitter on
  // --------------------------------------------------------------------------
  logic [31:0] sil;
  logic [31:0] qui;
  logic [31:0] en;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sil <= 32'h0;
      qui <= 32'h0;
      en  <= 32'h0;
    end else begin
      sil <= rx_char_pulse ? 32'h0 : sil + 32'h1;
      qui <= rx_msg_done ? 32'h0 : qui + 32'h1;
      en  <= tx_enable ? en + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer not one cycle");
  property p_go_en;
    tx_go |-> tx_enable;
  endproperty
  a_go_en: assert property (p_go_en) else $error("data start without tx");
  property p_tx_wait;
    $rose(tx_enable) |-> qui + 32'h1 >= MS_CYCLES;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("tx enabled too early");
  property p_go_gap;
    tx_go |-> en == 32'h0 || en + 32'h1 >= MS_CYCLES;
  endproperty
  a_go_gap: assert property (p_go_gap) else $error("data start gap wrong");
  property p_silence;
    msg_end_pulse |-> (sil + 32'h1) * 2 >= 32'(char_time_cycles) * 7;
  endproperty
  a_silence: assert property (p_silence) else $error("message end too soon");
  property p_frame;
    stop_bits_two |-> parity_mode == 2'h0 ##1 parity_mode != 2'h3;
  endproperty
  a_frame: assert property (p_frame) else $error("illegal framing");
  property p_fault;
    fault_in != 6'h00 |-> ##[0:4] option_slot_fault_trip;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not trip");
  property p_preset;
    preset_speed_load |=> !preset_speed_load;
  endproperty
  a_preset: assert property (p_preset) else $error("preset load not a pulse");
endmodule // bsl_chk

// ### bsl_host.sv
// Network master model: sends characters, messages and tokens, queues one response.
// Assumes the supervisor's clock; every event is a one-cycle pulse.
`timescale 1ns/10ps
module bsl_host (
  input  wire clk,
  input  wire tx_go,
  output reg  rx_char_pulse,
  output reg  rx_msg_done,
  output reg  rx_msg_crc_err,
  output reg  token_seen,
  output reg  response_ready
);
  initial begin
    rx_char_pulse = 1'b0;
    rx_msg_done = 1'b0;
    rx_msg_crc_err = 1'b0;
    token_seen = 1'b0;
    response_ready = 1'b0;
  end
  // Four characters, then the end event; the host keeps traffic within the timeout.
  task automatic send_msg(input logic bad);
    repeat (4) begin
      @(posedge clk) rx_char_pulse <= 1'b1;
      @(posedge clk) rx_char_pulse <= 1'b0;
      repeat (3) @(posedge clk);
    end
    @(posedge clk) rx_msg_crc_err <= bad;
    rx_msg_done <= 1'b1;
    @(posedge clk) rx_msg_done <= 1'b0;
    rx_msg_crc_err <= 1'b0;
  endtask
  task automatic send_token;
    @(posedge clk) token_seen <= 1'b1;
    @(posedge clk) token_seen <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rx_msg_done && !rx_msg_crc_err) response_ready <= 1'b1;
    else if (tx_go) response_ready <= 1'b0;
  end
endmodule // bsl_host

// ### tb.sv
// Self-checking bench of the link supervisor through its Avalon-MM registers and its output ports.
// Assumes bsl_regs.vh, the host model and the checker are compiled before it.
`timescale 1ns/10ps
`include "bsl_regs.vh"
module tb;
  localparam MS = 10;
  localparam [47:0] CODES = {`BSL_ERR_OVERTEMP, `BSL_ERR_NETWORK, `BSL_ERR_DRIVE_IF,
                             `BSL_ERR_FAN, `BSL_ERR_RTC, `BSL_ERR_OS};
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [5:0]  avs_address = 6'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [1:0]  protocol_sel = 2'h0;
  reg  [5:0]  fault_in = 6'h00;
  reg  [15:0] char_time_cycles = 16'h0004;
  reg  [31:0] q;
  wire [31:0] avs_readdata;
  wire [1:0]  parity_mode;
  wire        avs_waitrequest, rx_char_pulse, rx_msg_done, rx_msg_crc_err, token_seen;
  wire        response_ready, msg_end_pulse, msg_accept, tx_enable, tx_go, stop_bits_two;
  wire        option_slot_fault_trip, preset_speed_load, irq;
  integer     miscompares = 0, checks_done = 0, pre_cnt = 0, acc_cnt = 0, end_cnt = 0, i, n, ne;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    pre_cnt <= pre_cnt + preset_speed_load;
    acc_cnt <= acc_cnt + msg_accept;
    end_cnt <= end_cnt + msg_end_pulse;
  end
  bsl_link_supervisor #(.MS_CYCLES(MS), .MS_PER_S(10)) u_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .protocol_sel(protocol_sel),
    .char_time_cycles(char_time_cycles), .rx_char_pulse(rx_char_pulse),
    .rx_msg_done(rx_msg_done), .rx_msg_crc_err(rx_msg_crc_err), .token_seen(token_seen),
    .response_ready(response_ready), .fault_in(fault_in), .msg_end_pulse(msg_end_pulse),
    .msg_accept(msg_accept), .tx_enable(tx_enable), .tx_go(tx_go),
    .stop_bits_two(stop_bits_two), .parity_mode(parity_mode),
    .option_slot_fault_trip(option_slot_fault_trip),
    .preset_speed_load(preset_speed_load), .irq(irq));
  bsl_host u_host (.clk(clk), .tx_go(tx_go), .rx_char_pulse(rx_char_pulse),
    .rx_msg_done(rx_msg_done), .rx_msg_crc_err(rx_msg_crc_err), .token_seen(token_seen),
    .response_ready(response_ready));
  // --------------------------------------------------------------------------
  // Bus cycles and comparisons
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    integer k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) chk("waitrequest", 32'h0, 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  function automatic logic [2:0] fmt_exp(input logic [1:0] p, input logic [7:0] f);
    case (f)
      `BSL_FMT_N1: fmt_exp = 3'b000;
      `BSL_FMT_N2: fmt_exp = 3'b100;
      `BSL_FMT_E1: fmt_exp = {1'b0, `BSL_PAR_EVEN};
      `BSL_FMT_O1: fmt_exp = {1'b0, `BSL_PAR_ODD};
      default: fmt_exp = (p == `BSL_PROTO_MODBUS) ? 3'b100 : 3'b000;
    endcase
  endfunction
  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("frame_format_select", `BSL_OFS_FRAME_FMT, 32'h0);
    rd("response_turnaround_ms", `BSL_OFS_TURNAROUND, 32'h5);
    rd("crc_error_counter", `BSL_OFS_CRC_COUNT, 32'h0);
    rd("unmapped", 6'h3c, 32'h0);
    for (i = 0; i < 8; i++) begin
      protocol_sel <= (i < 6) ? 2'h0 : i - 5;
      wr(`BSL_OFS_FRAME_FMT, (i < 6) ? i : 9 * (i - 6));
      repeat (3) @(posedge clk);
      chk("framing", fmt_exp((i < 6) ? 0 : i - 5, (i < 6) ? i : 9 * (i - 6)),
          {stop_bits_two, parity_mode});
    end
    protocol_sel <= `BSL_PROTO_MODBUS;
    char_time_cycles <= 16'h0008;
    wr(`BSL_OFS_TURNAROUND, 32'h0);
    u_host.send_msg(1'b1);
    repeat (22) @(posedge clk);
    chk("msg end early", 0, end_cnt);
    repeat (18) @(posedge clk);
    chk("msg end", 1, end_cnt);
    rd("crc_error_counter", `BSL_OFS_CRC_COUNT, 32'h1);
    chk("tx_enable", 32'h0, tx_enable);
    for (i = 0; i < 3; i++) begin
      wr(`BSL_OFS_TURNAROUND, i);
      u_host.send_msg(1'b0);
      n = 0;
      while (tx_enable !== 1'b1 && n < 500) begin @(posedge clk); n++; end
      ne = 0;
      while (tx_go !== 1'b1 && ne < 50) begin @(posedge clk); ne++; end
      chk("enable delay", 1, n >= (i > 1 ? i : 1) * MS && n < 500);
      chk("go delay", (i == 0) ? 0 : MS, ne);
      repeat (40) @(posedge clk);
    end
    chk("accepted", 3, acc_cnt);
    chk("msg ends", 4, end_cnt);
    protocol_sel <= `BSL_PROTO_BACNET;
    wr(`BSL_OFS_LOSS_TIMEOUT, 32'h3);
    wr(`BSL_OFS_LOSS_ACTION, `BSL_ACT_PRESET);
    wr(`BSL_OFS_IRQ_STATUS, 32'hf);
    wr(`BSL_OFS_IRQ_MASK, 32'h4);
    repeat (5) begin u_host.send_token; repeat (100) @(posedge clk); end
    rd("link_ok_flag", `BSL_OFS_LINK_OK, 32'h1);
    repeat (280) @(posedge clk);
    chk("early preset", 0, pre_cnt + irq);
    repeat (160) @(posedge clk);
    chk("preset load", 1, pre_cnt);
    chk("irq", 1, irq);
    rd("link_ok_flag", `BSL_OFS_LINK_OK, 32'h0);
    wr(`BSL_OFS_IRQ_STATUS, 32'h4);
    u_host.send_token;
    repeat (4) @(posedge clk);
    chk("irq", 0, irq);
    rd("link_ok_flag", `BSL_OFS_LINK_OK, 32'h1);
    protocol_sel <= `BSL_PROTO_TRAFFIC;
    wr(`BSL_OFS_LOSS_ACTION, `BSL_ACT_TRIP);
    repeat (4) begin u_host.send_msg(1'b0); repeat (300) @(posedge clk); end
    chk("trip", 0, option_slot_fault_trip);
    repeat (250) @(posedge clk);
    chk("trip", 1, option_slot_fault_trip);
    rd("module_error_code", `BSL_OFS_ERR_CODE, `BSL_ERR_NETWORK);
    u_host.send_msg(1'b0);
    rd("link_ok_flag", `BSL_OFS_LINK_OK, 32'h1);
    wr(`BSL_OFS_CONTROL, 32'h1);
    for (i = 0; i < 6; i++) begin
      fault_in <= 6'h01 << i;
      repeat (5) @(posedge clk);
      chk("trip", 1, option_slot_fault_trip);
      rd("module_error_code", `BSL_OFS_ERR_CODE, CODES[8*i +: 8]);
      fault_in <= 6'h00;
      wr(`BSL_OFS_CONTROL, 32'h1);
      rd("module_error_code", `BSL_OFS_ERR_CODE, `BSL_ERR_NONE);
    end
    report_and_stop;
  end
endmodule // tb
bind bsl_link_supervisor bsl_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk),
  .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .char_time_cycles(char_time_cycles),
  .rx_char_pulse(rx_char_pulse), .rx_msg_done(rx_msg_done), .fault_in(fault_in),
  .msg_end_pulse(msg_end_pulse), .tx_enable(tx_enable), .tx_go(tx_go),
  .stop_bits_two(stop_bits_two), .parity_mode(parity_mode),
  .option_slot_fault_trip(option_slot_fault_trip), .preset_speed_load(preset_speed_load));
